/* hsdp_defs.vh */
// Constants for the host slave data phase bridge block
`ifndef HSDP_DEFS_VH
`define HSDP_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define HSDP_OFS_MISC      8'h00
`define HSDP_OFS_MISC2     8'h04
`define HSDP_OFS_IMG0      8'h08
`define HSDP_OFS_IMG1      8'h0C
`define HSDP_OFS_STATUS    8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define HSDP_BIT_BYTE_ORDER 0
`define HSDP_BIT_SPEEDUP    0
`define HSDP_BIT_POST_EN    0
`define HSDP_BIT_SPACE      1
`define HSDP_RST_MISC       1'h0
`define HSDP_RST_MISC2      1'h0
`define HSDP_RST_IMG        2'h0

// ----------------------------------------
// PCI commands
// ----------------------------------------
`define HSDP_CMD_IO_RD     4'h2
`define HSDP_CMD_IO_WR     4'h3
`define HSDP_CMD_MEM_RD    4'h6
`define HSDP_CMD_MEM_WR    4'h7

// ----------------------------------------
// Queue entry counts and timing counts
// ----------------------------------------
`define HSDP_SINGLE_ENTRIES 7'h02
`define HSDP_BURST_ENTRIES  7'h05
`define HSDP_BURST_BEATS    2'h3
`define HSDP_GAP_SLOW       2'h2
`define HSDP_GAP_FAST       2'h0

`endif

/* hsdp_host_slave_data_phase.v */
// Data phase of the host slave channel: lane mapping, write queue, reads
//
// Function
// - PCI little-endian; host big-endian unless selected
// - Little-endian keeps lanes, translates byte addressing
// - Size codes decoded, clipped at word boundary
// - Big-endian swaps byte lanes, addressing preserved
// - Post single writes when image enables it
// - Image-select level picks image control register
// - Burst writes are always posted
// - Posted write acknowledged once queued
// - One delayed write; others retried meanwhile
// - Address entry then data entries queued
// - Attributes captured at queue time
// - Narrow writes never merged into entries
// - Retry single write unless two entries free
// - Request PCI for writes only with a complete queued transaction
// - Burst write takes five entries, retried unless five free
// - Bursts forwarded with linear incrementing addresses
// - Burst write to I/O or registers errors
// - Speed-up bit shortens idle gap between writes
// - Latch read, retry later cycles until done
// - Read via PCI into return queue, terminate normally
// - Burst read to I/O or registers errors
// - Burst read delivers four beats
// - Memory images map to memory, I/O to I/O
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "hsdp_defs.vh"

module hsdp_host_slave_data_phase #(
  parameter QDEPTH = 64,                // Write queue entries (256 bytes)
  parameter QAW    = 6                  // Write queue pointer width
) (
  input  wire        ref_clk,           // Core clock, host bus clock
  input  wire        rst_b,             // Asynchronous reset, active low
  input  wire        ce,                // Clock enable, freezes all state but the reset synchronizer
  input  wire [7:0]  regAddr,           // Register byte address
  input  wire [31:0] regWrData,         // Register write data
  input  wire        regWr,             // Register write strobe
  input  wire        regRd,             // Register read strobe
  output reg  [31:0] regRdData,         // Register read data, next cycle
  input  wire        hostStart,         // Host cycle start pulse
  input  wire        hostWrite,         // Cycle is a write
  input  wire        hostBurst,         // Cycle is a four-beat burst
  input  wire        hostRegHit,        // Cycle targets own registers
  input  wire [31:0] hostAddr,          // Host address
  input  wire [31:0] hostWrData,        // Host write data, host lanes
  input  wire [1:0]  transferSizeCode,  // Size code of the cycle
  input  wire        imageSelect,       // Picks slave image 0 or 1
  input  wire        hostBeat,          // Burst write data beat valid
  output reg         hostAck,           // Data acknowledge pulse
  output reg         hostRetry,         // Retry pulse
  output reg         hostBusErr,        // Bus error pulse
  output reg  [31:0] hostRdData,        // Read data with hostAck
  input  wire        pciClk,            // PCI clock, sampled
  input  wire        pciGnt,            // Bus grant
  input  wire        pciTrdy,           // Target took or gave a beat
  input  wire        pciAbort,          // Target ended with error
  input  wire [31:0] pciAdIn,           // Read data from target
  output reg         pciReq,            // Bus request
  output reg         pciAddrPhase,      // Address phase valid
  output reg         pciDataPhase,      // Data phase valid
  output reg         pciLast,           // Final data phase
  output reg  [31:0] pciAdOut,          // Address or write data
  output reg  [3:0]  pciCbe             // Command or byte enables, low
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam H_IDLE  = 6'b000001;
  localparam H_WD    = 6'b000010;
  localparam H_BURST = 6'b000100;
  localparam H_DWR   = 6'b001000;
  localparam H_RD    = 6'b010000;
  localparam H_RET   = 6'b100000;
  localparam M_IDLE  = 3'b001;
  localparam M_WDATA = 3'b010;
  localparam M_RDATA = 3'b100;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [1:0]  rstSync_q;
  wire        rstN;
  reg  [35:0] syncA_q;
  reg  [35:0] syncB_q;
  reg         pciClkPrev_q;
  wire        pciEdge;
  reg         hostByteOrderCtl_q;
  reg         postedWriteSpeedup_q;
  reg  [1:0]  slaveImageControl0_q;
  reg  [1:0]  slaveImageControl1_q;
  wire [1:0]  selCtl;
  wire        leMode;
  wire [35:0] wrMap;
  wire [35:0] burstMap;
  wire [35:0] rdMap;
  reg  [37:0] outboundWriteQueue [0:QDEPTH-1];
  reg  [QAW-1:0] qWrPtr_q;
  reg  [QAW-1:0] qRdPtr_q;
  reg  [QAW:0]   qCount_q;
  reg  [QAW:0]   qTxn_q;
  wire [QAW:0]   qFree;
  reg         pushEn_q;
  reg  [37:0] pushEnt_q;
  wire        pop;
  wire [37:0] qHead;
  wire [37:0] qNext;
  reg  [31:0] readReturnQueue [0:3];
  reg  [1:0]  rrqWrIdx_q;
  reg  [5:0]  hState_q;
  reg  [1:0]  beatCnt_q;
  reg  [35:0] pendData_q;
  reg         pendDly_q;
  reg  [31:0] rdAddr_q;
  reg  [3:0]  rdCmd_q;
  reg  [3:0]  rdBe_q;
  reg         rdBurst_q;
  reg         rdGo_q;
  reg         rdLe_q;
  reg  [2:0]  mState_q;
  reg  [1:0]  gapCnt_q;
  reg  [1:0]  rdBeatsLeft_q;
  reg         curDly_q;
  reg         mErr_q;
  reg         mWrDone_q;
  reg         mRdDone_q;
  reg         mPop_q;
  wire        mGnt;
  wire        mTrdy;
  wire        mAbort;
  wire [31:0] mAdIn;

  // ----------------------------------------
  // Lane and byte-enable mapping
  // ----------------------------------------
  // size decode with word clip
  function [35:0] laneMap;
    input [31:0] d;
    input [1:0]  off;
    input [1:0]  siz;
    input        le;
    integer      k;
    integer      n;
    reg   [3:0]  be;
    begin
      n  = (siz == 2'h0) ? 4 : siz;
      be = 4'hF;
      for (k = 0; k < 4; k = k + 1) begin
        if (k >= off && k < off + n) begin
          if (le)
            be[3-k] = 1'b0;
          // big-endian lane k to bit k
          else
            be[k] = 1'b0;
        end
      end
      laneMap = {be, le ? d : {d[7:0], d[15:8], d[23:16], d[31:24]}};
    end
  endfunction

  // ----------------------------------------
  // Reset release and PCI input crossing
  // ----------------------------------------
  // Reset released through two flops
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      rstSync_q <= 2'h0;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // two-flop capture of PCI inputs
  // Data sampled only on clock edges, long after it settled
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      syncA_q      <= 36'h0;
      syncB_q      <= 36'h0;
      pciClkPrev_q <= 1'b0;
    end else if (ce) begin
      syncA_q      <= {pciClk, pciGnt, pciTrdy, pciAbort, pciAdIn};
      syncB_q      <= syncA_q;
      pciClkPrev_q <= syncB_q[35];
    end
  end
  assign pciEdge = syncB_q[35] & ~pciClkPrev_q;
  assign mGnt    = syncB_q[34];
  assign mTrdy   = syncB_q[33];
  assign mAbort  = syncB_q[32];
  assign mAdIn   = syncB_q[31:0];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Software writes and one-cycle read data
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      hostByteOrderCtl_q   <= `HSDP_RST_MISC;
      postedWriteSpeedup_q <= `HSDP_RST_MISC2;
      slaveImageControl0_q <= `HSDP_RST_IMG;
      slaveImageControl1_q <= `HSDP_RST_IMG;
      regRdData            <= 32'h0;
    end else if (ce) begin
      regRdData <= 32'h0;
      if (regWr) begin
        case (regAddr)
          `HSDP_OFS_MISC:
            hostByteOrderCtl_q <= regWrData[`HSDP_BIT_BYTE_ORDER];
          `HSDP_OFS_MISC2:
            postedWriteSpeedup_q <= regWrData[`HSDP_BIT_SPEEDUP];
          `HSDP_OFS_IMG0: slaveImageControl0_q <= regWrData[1:0];
          `HSDP_OFS_IMG1: slaveImageControl1_q <= regWrData[1:0];
          default: ;
        endcase
      end
      if (regRd) begin
        case (regAddr)
          `HSDP_OFS_MISC:   regRdData <= {31'h0, hostByteOrderCtl_q};
          `HSDP_OFS_MISC2:  regRdData <= {31'h0, postedWriteSpeedup_q};
          `HSDP_OFS_IMG0:   regRdData <= {30'h0, slaveImageControl0_q};
          `HSDP_OFS_IMG1:   regRdData <= {30'h0, slaveImageControl1_q};
          `HSDP_OFS_STATUS: regRdData <= {13'h0, mState_q, hState_q,
                                          3'h0, qCount_q};
          default:          regRdData <= 32'h0;
        endcase
      end
    end
  end

  assign selCtl = imageSelect ? slaveImageControl1_q
                              : slaveImageControl0_q;
  assign leMode   = hostByteOrderCtl_q;
  assign wrMap    = laneMap(hostWrData, hostAddr[1:0], transferSizeCode,
                            leMode);
  assign burstMap = laneMap(hostWrData, 2'h0, 2'h0, leMode);
  // Beat count rests at zero outside burst write and burst return, so singles read entry 0
  assign rdMap    = laneMap(readReturnQueue[beatCnt_q], 2'h0, 2'h0, rdLe_q);

  // ----------------------------------------
  // Outbound write queue
  // ----------------------------------------
  // Entry: last, delayed, enables or command, data or address
  assign qHead = outboundWriteQueue[qRdPtr_q];
  assign qNext = outboundWriteQueue[qRdPtr_q + 1'b1];
  assign pop   = mPop_q;
  // Pending push counts as used so back-to-back checks stay honest
  assign qFree = QDEPTH[QAW:0] - qCount_q - {{QAW{1'b0}}, pushEn_q};

  // Storage write port
  always @(posedge ref_clk) begin
    if (ce && pushEn_q)
      outboundWriteQueue[qWrPtr_q] <= pushEnt_q;
  end

  // Pointers, fill level and complete-transaction count
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      qWrPtr_q <= {QAW{1'b0}};
      qRdPtr_q <= {QAW{1'b0}};
      qCount_q <= {(QAW+1){1'b0}};
      qTxn_q   <= {(QAW+1){1'b0}};
    end else if (ce) begin
      if (pushEn_q)
        qWrPtr_q <= qWrPtr_q + 1'b1;
      if (pop)
        qRdPtr_q <= qRdPtr_q + 1'b1;
      qCount_q <= qCount_q + {{QAW{1'b0}}, pushEn_q}
                           - {{QAW{1'b0}}, pop};
      qTxn_q <= qTxn_q + {{QAW{1'b0}}, pushEn_q & pushEnt_q[37]}
                       - {{QAW{1'b0}}, pop & qHead[37]};
    end
  end

  // ----------------------------------------
  // Host side state machine
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      hState_q   <= H_IDLE;
      hostAck    <= 1'b0;
      hostRetry  <= 1'b0;
      hostBusErr <= 1'b0;
      hostRdData <= 32'h0;
      pushEn_q   <= 1'b0;
      pushEnt_q  <= 38'h0;
      beatCnt_q  <= 2'h0;
      pendData_q <= 36'h0;
      pendDly_q  <= 1'b0;
      rdAddr_q   <= 32'h0;
      rdCmd_q    <= 4'h0;
      rdBe_q     <= 4'h0;
      rdBurst_q  <= 1'b0;
      rdGo_q     <= 1'b0;
      rdLe_q     <= 1'b0;
    end else if (ce) begin
      hostAck    <= 1'b0;
      hostRetry  <= 1'b0;
      hostBusErr <= 1'b0;
      pushEn_q   <= 1'b0;
      case (hState_q)
        H_IDLE: begin
          if (hostStart) begin
            // burst write to I/O or registers
            // burst read to I/O or registers
            if (hostBurst && (selCtl[`HSDP_BIT_SPACE] || hostRegHit)) begin
              hostBusErr <= 1'b1;
            end else if (!hostWrite) begin
              rdAddr_q  <= {hostAddr[31:2], 2'h0};
              rdBurst_q <= hostBurst;
              rdLe_q    <= leMode;
              rdCmd_q   <= selCtl[`HSDP_BIT_SPACE] ? `HSDP_CMD_IO_RD
                                                   : `HSDP_CMD_MEM_RD;
              rdBe_q    <= hostBurst ? 4'h0 : wrMap[35:32];
              rdGo_q    <= 1'b1;
              hState_q  <= H_RD;
            end else if (hostBurst) begin
              if (qFree >= `HSDP_BURST_ENTRIES) begin
                pushEn_q  <= 1'b1;
                pushEnt_q <= {2'b00, `HSDP_CMD_MEM_WR,
                              hostAddr[31:4], 4'h0};
                beatCnt_q <= 2'h0;
                hState_q  <= H_BURST;
              end else begin
                hostRetry <= 1'b1;
              end
            end else if (qFree >= `HSDP_SINGLE_ENTRIES) begin
              pushEn_q   <= 1'b1;
              pushEnt_q  <= {1'b0, ~selCtl[`HSDP_BIT_POST_EN],
                             selCtl[`HSDP_BIT_SPACE] ? `HSDP_CMD_IO_WR
                                                     : `HSDP_CMD_MEM_WR,
                             hostAddr};
              pendData_q <= wrMap;
              pendDly_q  <= ~selCtl[`HSDP_BIT_POST_EN];
              hState_q   <= H_WD;
            end else begin
              hostRetry <= 1'b1;
            end
          end
        end
        H_WD: begin
          hostRetry <= hostStart;
          pushEn_q  <= 1'b1;
          pushEnt_q <= {1'b1, pendDly_q, pendData_q};
          if (pendDly_q) begin
            hState_q <= H_DWR;
          end else begin
            hostAck  <= 1'b1;
            hState_q <= H_IDLE;
          end
        end
        H_BURST: begin
          if (hostBeat) begin
            pushEn_q  <= 1'b1;
            pushEnt_q <= {beatCnt_q == `HSDP_BURST_BEATS, 1'b0, burstMap};
            hostAck   <= 1'b1;
            beatCnt_q <= beatCnt_q + 1'b1;
            if (beatCnt_q == `HSDP_BURST_BEATS)
              hState_q <= H_IDLE;
          end
        end
        H_DWR: begin
          hostRetry <= hostStart;
          if (mWrDone_q) begin
            hostAck    <= ~mErr_q;
            hostBusErr <= mErr_q;
            hState_q   <= H_IDLE;
          end
        end
        H_RD: begin
          hostRetry <= hostStart;
          if (mRdDone_q) begin
            rdGo_q    <= 1'b0;
            beatCnt_q <= 2'h0;
            if (mErr_q) begin
              hostBusErr <= 1'b1;
              hState_q   <= H_IDLE;
            end else if (rdBurst_q) begin
              hState_q <= H_RET;
            end else begin
              hostAck    <= 1'b1;
              hostRdData <= rdMap[31:0];
              hState_q   <= H_IDLE;
            end
          end
        end
        H_RET: begin
          hostRetry  <= hostStart;
          hostAck    <= 1'b1;
          hostRdData <= rdMap[31:0];
          beatCnt_q  <= beatCnt_q + 1'b1;
          if (beatCnt_q == `HSDP_BURST_BEATS)
            hState_q <= H_IDLE;
        end
        default: hState_q <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read return queue storage
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (ce && pciEdge && mState_q == M_RDATA && pciDataPhase && mTrdy)
      readReturnQueue[rrqWrIdx_q] <= mAdIn;
  end

  // ----------------------------------------
  // PCI master, stepped on sampled PCI edges
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      mState_q      <= M_IDLE;
      gapCnt_q      <= 2'h0;
      rdBeatsLeft_q <= 2'h0;
      rrqWrIdx_q    <= 2'h0;
      curDly_q      <= 1'b0;
      mErr_q        <= 1'b0;
      mWrDone_q     <= 1'b0;
      mRdDone_q     <= 1'b0;
      mPop_q        <= 1'b0;
      pciReq        <= 1'b0;
      pciAddrPhase  <= 1'b0;
      pciDataPhase  <= 1'b0;
      pciLast       <= 1'b0;
      pciAdOut      <= 32'h0;
      pciCbe        <= 4'hF;
    end else if (ce) begin
      mWrDone_q <= 1'b0;
      mRdDone_q <= 1'b0;
      mPop_q    <= 1'b0;
      if (pciEdge) begin
        pciAddrPhase <= 1'b0;
        case (mState_q)
          M_IDLE: begin
            pciDataPhase <= 1'b0;
            pciLast      <= 1'b0;
            if (gapCnt_q != 2'h0) begin
              gapCnt_q <= gapCnt_q - 1'b1;
            end else if (qTxn_q != {(QAW+1){1'b0}}) begin
              pciReq <= 1'b1;
              if (pciReq && mGnt) begin
                pciAddrPhase <= 1'b1;
                pciAdOut     <= qHead[31:0];
                pciCbe       <= qHead[35:32];
                curDly_q     <= qHead[36];
                mErr_q       <= 1'b0;
                mPop_q       <= 1'b1;
                mState_q     <= M_WDATA;
              end
            // Reads wait for the write queue to drain
            end else if (rdGo_q && !mRdDone_q && hState_q == H_RD &&
                         qCount_q == {(QAW+1){1'b0}} && !pushEn_q) begin
              pciReq <= 1'b1;
              if (pciReq && mGnt) begin
                pciAddrPhase  <= 1'b1;
                pciAdOut      <= rdAddr_q;
                pciCbe        <= rdCmd_q;
                rdBeatsLeft_q <= rdBurst_q ? `HSDP_BURST_BEATS : 2'h0;
                rrqWrIdx_q    <= 2'h0;
                mErr_q        <= 1'b0;
                mState_q      <= M_RDATA;
              end
            end else begin
              pciReq <= 1'b0;
            end
          end
          M_WDATA: begin
            if (!pciDataPhase) begin
              pciDataPhase <= 1'b1;
              pciAdOut     <= qHead[31:0];
              pciCbe       <= qHead[35:32];
              pciLast      <= qHead[37];
            end else if (mTrdy || mAbort) begin
              mPop_q <= 1'b1;
              mErr_q <= mErr_q | mAbort;
              if (pciLast) begin
                pciReq       <= 1'b0;
                pciDataPhase <= 1'b0;
                pciLast      <= 1'b0;
                mWrDone_q    <= curDly_q;
                gapCnt_q     <= postedWriteSpeedup_q ? `HSDP_GAP_FAST
                                                     : `HSDP_GAP_SLOW;
                mState_q     <= M_IDLE;
              end else begin
                pciAdOut <= qNext[31:0];
                pciCbe   <= qNext[35:32];
                pciLast  <= qNext[37];
              end
            end
          end
          M_RDATA: begin
            if (!pciDataPhase) begin
              pciDataPhase <= 1'b1;
              pciCbe       <= rdBe_q;
              pciLast      <= rdBeatsLeft_q == 2'h0;
            end else if (mTrdy || mAbort) begin
              rrqWrIdx_q    <= rrqWrIdx_q + 1'b1;
              rdBeatsLeft_q <= rdBeatsLeft_q - 1'b1;
              pciLast       <= rdBeatsLeft_q == 2'h1;
              mErr_q        <= mErr_q | mAbort;
              if (pciLast || mAbort) begin
                pciReq       <= 1'b0;
                pciDataPhase <= 1'b0;
                pciLast      <= 1'b0;
                mRdDone_q    <= 1'b1;
                mState_q     <= M_IDLE;
              end
            end
          end
          default: mState_q <= M_IDLE;
        endcase
      end
    end
  end

endmodule

/* hsdp_host_slave_data_phase_assertions.sv */
// Port checks for the host slave data phase block
`timescale 1ns/10ps
module hsdp_sva (
  input wire logic       ref_clk,      // Core clock
  input wire logic       rst_b,        // Reset
  input wire logic       hostStart,    // Start
  input wire logic       hostWrite,    // Write
  input wire logic       hostBurst,    // Burst
  input wire logic       hostRegHit,   // Own regs
  input wire logic       hostAck,      // Ack
  input wire logic       hostRetry,    // Retry
  input wire logic       hostBusErr,   // Error
  input wire logic       pciReq,       // Request
  input wire logic       pciAddrPhase, // Address
  input wire logic       pciDataPhase, // Data
  input wire logic       pciLast,      // Last beat
  input wire logic [3:0] pciCbe        // Command
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Busy slave may retry instead of erroring
  wire brg = hostStart && hostBurst && hostRegHit;
  property p_bwReg; brg && hostWrite |=> hostBusErr || hostRetry; endproperty
  a_bwReg: assert property (p_bwReg)
    else $error("burst write to registers not refused");
  property p_brReg; brg && !hostWrite |=> hostBusErr || hostRetry; endproperty
  a_brReg: assert property (p_brReg)
    else $error("burst read to registers not refused");
  property p_early; hostStart && !hostBurst |=> !hostAck; endproperty
  a_early: assert property (p_early)
    else $error("single access acknowledged too early");
  property p_excl; hostAck |-> !hostRetry && !hostBusErr; endproperty
  a_excl: assert property (p_excl)
    else $error("acknowledge mixed with retry or error");
  property p_req; $rose(pciAddrPhase) |-> $past(pciReq); endproperty
  a_req: assert property (p_req)
    else $error("address phase without request");
  property p_cmd; $rose(pciAddrPhase) |-> !pciCbe[3] && pciCbe[1]; endproperty
  a_cmd: assert property (p_cmd)
    else $error("command not a memory or io access");
  property p_ad; $fell(pciAddrPhase) |-> pciDataPhase; endproperty
  a_ad: assert property (p_ad)
    else $error("address phase not followed by data");
  property p_last; pciLast |-> pciDataPhase; endproperty
  a_last: assert property (p_last)
    else $error("last flag outside data phase");
  c_ack: cover property (hostAck);
  c_err: cover property (hostBusErr);
  c_addr: cover property ($rose(pciAddrPhase));
endmodule
bind hsdp_host_slave_data_phase hsdp_sva u_hsdp_sva (
  .ref_clk, .rst_b, .hostStart, .hostWrite, .hostBurst, .hostRegHit,
  .hostAck, .hostRetry, .hostBusErr, .pciReq, .pciAddrPhase,
  .pciDataPhase, .pciLast, .pciCbe);

/* hsdp_pci_target.sv */
// PCI arbiter and target stand-in
`timescale 1ns/10ps
module hsdp_pci_target (
  input  wire logic        pciClk,       // PCI clock
  input  wire logic        pciReq,       // Request
  input  wire logic        pciDataPhase, // Beat offered
  input  wire logic [31:0] rdWord,       // Read word
  output      logic        pciGnt,       // Grant
  output      logic        pciTrdy,      // Beat done
  output      logic        pciAbort,     // Never raised
  output      logic [31:0] pciAdIn       // Read lanes
);
  initial {pciGnt, pciTrdy, pciAbort, pciAdIn} = '0;
  // one wait state, idle lanes inverted
  always @(posedge pciClk) begin
    pciGnt   <= pciReq;
    pciTrdy  <= pciDataPhase && !pciTrdy;
    pciAdIn  <= pciDataPhase ? rdWord : ~rdWord;
  end
endmodule

/* hsdp_host_slave_data_phase_tb.sv */
// Self-checking bench for the host slave data phase block
`timescale 1ns/10ps
module hsdp_host_slave_data_phase_tb;
  logic        ref_clk = 1'h0, rst_b = 1'h0, pciClk = 1'h0, ce = 1'h1;
  logic        regWr = 1'h0, regRd = 1'h0, hostStart = 1'h0, hostBeat = 1'h0;
  logic        hostWrite = 1'h0, hostBurst = 1'h0, hostRegHit = 1'h0;
  logic        imageSelect = 1'h0;
  logic [1:0]  transferSizeCode = 2'h0;
  logic [7:0]  regAddr = 8'h0;
  logic [31:0] regWrData = '0, hostAddr = '0, hostWrData = '0, rdWord = '0;
  logic [31:0] regRdData, hostRdData, pciAdIn, pciAdOut;
  logic [3:0]  pciCbe;
  logic        hostAck, hostRetry, hostBusErr, pciGnt, pciTrdy, pciAbort;
  logic        pciReq, pciAddrPhase, pciDataPhase, pciLast;
  logic [39:0] q[$];
  int          errorCnt = 0, compares = 0, cyc = 0, n;
  // Lane cases: size, offset, enables, host word; then PCI word
  logic [39:0] wv [5] = '{40'h4EA1000000, 40'h0011223344, 40'h47A1000000,
                          40'hFE000000D4, 40'h9900B2C100};
  logic [31:0] pv [5] = '{32'h000000A1, 32'h44332211, 32'hA1000000,
                          32'h000000D4, 32'h00B2C100};
  hsdp_host_slave_data_phase u_hsdp_host_slave_data_phase (
    .ref_clk, .rst_b, .ce, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .hostStart, .hostWrite, .hostBurst, .hostRegHit, .hostAddr, .hostWrData,
    .transferSizeCode, .imageSelect, .hostBeat, .hostAck, .hostRetry,
    .hostBusErr, .hostRdData, .pciClk, .pciGnt, .pciTrdy, .pciAbort,
    .pciAdIn, .pciReq, .pciAddrPhase, .pciDataPhase, .pciLast, .pciAdOut,
    .pciCbe);
  hsdp_pci_target u_hsdp_pci_target (.pciClk, .pciReq, .pciDataPhase,
    .rdWord, .pciGnt, .pciTrdy, .pciAbort, .pciAdIn);
  always #20 ref_clk = ~ref_clk;
  always #160 pciClk = ~pciClk;
  // Log each PCI phase once, as the target takes it
  always @(posedge pciClk)
    if (pciAddrPhase || (pciDataPhase && !pciTrdy))
      q.push_back({3'h0, pciAddrPhase, pciCbe, pciAdOut});
  task automatic summarize;
    $display("compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      summarize();
    end
  end
  task automatic chk(input logic [39:0] got, exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'h1;
    @(posedge ref_clk);
    regWr     <= 1'h0;
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge ref_clk);
    regRd   <= 1'h0;
    @(posedge ref_clk);
    chk(regRdData, e);
  endtask
  // One host cycle; n counts edges until any response
  task automatic host(input logic w, b, r, input logic [1:0] s,
                      input logic [31:0] a, d);
    hostWrite        <= w;
    hostBurst        <= b;
    hostRegHit       <= r;
    transferSizeCode <= s;
    hostAddr         <= a;
    hostWrData       <= d;
    hostStart        <= 1'h1;
    @(posedge ref_clk);
    hostStart        <= 1'h0;
    n = 0;
    while ((hostAck | hostRetry | hostBusErr) !== 1'h1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic pq(input logic [39:0] e);
    n = 0;
    while (q.size() == 0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(q.size() > 0 ? q.pop_front() : '1, e);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    repeat (5) @(posedge ref_clk);
    rr(8'h00, 32'h0);
    rr(8'h14, 32'h0);
    rw(8'h08, 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (i == 1) rw(8'h08, 32'h1);
      if (i == 2) rw(8'h00, 32'h1);
      host(1'h1, 1'h0, 1'h0, wv[i][39:38], {30'h40, wv[i][37:36]},
           wv[i][31:0]);
      chk(n, 2);
      if (i == 0) rw(8'h08, 32'h3);
      pq({8'h17, 30'h40, wv[i][37:36]});
      pq({4'h0, wv[i][35:32], pv[i]});
    end
    imageSelect <= 1'h1;
    host(1'h1, 1'h0, 1'h0, 2'h0, 32'h300, 32'h5A5A5A5A);
    chk(n > 3, 1);
    pq({8'h17, 32'h300});
    pq({8'h00, 32'h5A5A5A5A});
    rw(8'h0C, 32'h2);
    rr(8'h0C, 32'h2);
    host(1'h1, 1'h0, 1'h0, 2'h0, 32'h600, 32'h0);
    pq({8'h13, 32'h600});
    q.delete();
    for (int i = 0; i < 4; i++) begin
      imageSelect <= i[1];
      host(!i[0], 1'h1, !i[1], 2'h0, 32'h500, 32'h0);
      chk({hostBusErr, n[7:0]}, 9'h101);
    end
    imageSelect <= 1'h0;
    rdWord      <= 32'h44332211;
    rw(8'h00, 32'h0);
    host(1'h0, 1'h0, 1'h0, 2'h0, 32'h400, 32'h0);
    chk(hostRdData, 32'h11223344);
    pq({8'h16, 32'h400});
    host(1'h0, 1'h1, 1'h0, 2'h0, 32'h400, 32'h0);
    for (int i = 0; i < 5; i++) begin
      chk({hostAck, hostRdData}, {i < 4, 32'h11223344});
      @(posedge ref_clk);
    end
    summarize();
  end
endmodule
